// >>> rtl/rmrf_pkg.sv
// Constants, register map and record layout of the measurement record framer
package rmrf_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_INT_STAT = 8'h08;
	localparam logic [7:0] REG_INT_CLR = 8'h0c;
	localparam logic [7:0] REG_INT_EN = 8'h10;
	localparam logic [3:0] SAT_PAGE = 4'h2;
	localparam logic [3:0] FLAG_PAGE = 4'h3;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	localparam logic CTRL_ENABLE_RST = 1'b1;
	localparam int NUM_EVENTS = 3;
	localparam int EV_RECORD_DONE = 0;
	localparam int EV_QUERY_DONE = 1;
	localparam int EV_QUERY_REFUSED = 2;
	localparam logic [NUM_EVENTS-1:0] INT_EN_RST = 3'h0;
	localparam logic [31:0] SAT_RST = 32'h0;
	localparam logic [31:0] FLAG_RST = 32'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Record layout
	// ----------------------------------------------------------------
	localparam int NUM_ANT = 4;
	localparam int HDR_LEN = 11;
	localparam int REC_LEN = 21;
	localparam logic [87:0] HDR_BYTES = 88'h24_50_41_53_48_52_2c_4d_43_41_2c;
	localparam logic [4:0] IDX_TAG_HI = 5'd11;
	localparam logic [4:0] IDX_TAG_LO = 5'd12;
	localparam logic [4:0] IDX_REMAIN = 5'd13;
	localparam logic [4:0] IDX_CODE = 5'd14;
	localparam logic [4:0] IDX_ELEV = 5'd15;
	localparam logic [4:0] IDX_AZ_HI = 5'd16;
	localparam logic [4:0] IDX_AZ_LO = 5'd17;
	localparam logic [4:0] IDX_CHAN = 5'd18;
	localparam logic [4:0] IDX_WARN = 5'd19;
	localparam logic [4:0] IDX_CSUM = 5'd20;

	// ----------------------------------------------------------------
	// Field limits and warning weights
	// ----------------------------------------------------------------
	localparam logic [6:0] ELEV_MAX = 7'd90;
	localparam logic [8:0] AZ_MAX = 9'd360;
	localparam logic [5:0] CHAN_MIN = 6'd1;
	localparam logic [5:0] CHAN_MAX = 6'd32;
	localparam logic [2:0] SYNC_FULL = 3'd5;
	localparam logic [7:0] W_RANGE = 8'h01;
	localparam logic [7:0] W_CLOCK = 8'h02;
	localparam logic [7:0] W_SYNC = 8'h04;
	localparam logic [7:0] W_FALSE_LOCK = 8'h40;
	localparam logic [7:0] W_LOCK_LOST = 8'h80;

	// ----------------------------------------------------------------
	// Sequence tag timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TAG_PERIOD_MS = 50;
	localparam int TAG_TICK_CYCLES = TAG_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [15:0] TAG_LAST = 16'd35999;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_SEND
	} rmrf_state_e;

endpackage

// >>> rtl/rmrf_sat_field.sv
// Per-antenna satellite field conditioning and warning word composition
`timescale 1ns/1ps
module rmrf_sat_field
	import rmrf_pkg::*;
(
	// Raw software words
	input wire logic [31:0] sat_word,
	input wire logic [31:0] flag_word,
	// Conditioned record fields
	output logic [7:0] code,
	output logic [6:0] elev,
	output logic [8:0] az,
	output logic [5:0] chan,
	output logic [7:0] warn
);

	logic [2:0] sync_raw;
	logic [2:0] sync_stage;

	// ----------------------------------------------------------------
	// Identity and angles
	// ----------------------------------------------------------------
	// Clamping keeps a bad software value from breaking the range
	always_comb begin
		code = sat_word[7:0];
		elev = (sat_word[14:8] > ELEV_MAX) ? ELEV_MAX : sat_word[14:8];
		az = (sat_word[24:16] > AZ_MAX) ? AZ_MAX : sat_word[24:16];
		if (sat_word[30:25] < CHAN_MIN) begin
			chan = CHAN_MIN;
		end else if (sat_word[30:25] > CHAN_MAX) begin
			chan = CHAN_MAX;
		end else begin
			chan = sat_word[30:25];
		end
	end

	// ----------------------------------------------------------------
	// Warning word
	// ----------------------------------------------------------------
	// Stage values past full lock are treated as full lock
	assign sync_raw = flag_word[4:2];
	assign sync_stage = (sync_raw > SYNC_FULL) ? SYNC_FULL : sync_raw;

	// Distinct weights, so OR of the terms equals their sum
	always_comb begin
		warn = 8'h00;
		if (flag_word[0]) begin
			warn = warn | W_RANGE;
		end
		if (flag_word[1]) begin
			warn = warn | W_CLOCK;
		end
		if (sync_stage < SYNC_FULL) begin
			warn = warn | W_SYNC;
		end
		if (flag_word[5]) begin
			warn = warn | W_LOCK_LOST;
		end
		warn = warn & ~W_FALSE_LOCK;
	end

endmodule

// >>> rtl/rmrf_framer.sv
// Raw measurement record framer with AXI4-Lite register slave
//
// Operation
// - A query sends records for antennas one to four, in ascending order.
// - Every record starts with the fixed header string for resynchronising.
// - Sequence tag counts 50 ms units and returns to zero every 30 min.
// - All records of one epoch carry the same sequence tag value.
// - Each record carries the count of records still to come this epoch.
// - Each record names its satellite by the satellite code number.
// - Elevation is whole degrees, limited to 0 through 90.
// - Azimuth is degrees, limited to 0 through 360.
// - Channel index lies between 1 and 32.
// - Warning weight 1 means satellite range nears a 1 ms offset.
// - Warning weight 2 means receiver clock offset is near 1 ms.
// - Warning weight 4 means synchronisation stage is below 5.
// - Warning weight 64 stays cleared in the stored record form.
// - Warning weight 128 means lock was lost in the previous epoch.
// - Warning word is the sum of all active independent weights.
// - Checksum is the bytewise XOR from sequence tag up to checksum.
// - Synchronisation stage runs 0 to 4, reaching 5 at full lock.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module rmrf_framer
	import rmrf_pkg::*;
#(
	parameter int TICK_CYCLES = TAG_TICK_CYCLES
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Record byte stream
	output logic rec_valid,
	input wire logic rec_ready,
	output logic [7:0] rec_data,
	output logic rec_first,
	output logic rec_last,
	// Interrupt
	output logic irq
);

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [4:0] REC_LAST_IDX = 5'(REC_LEN - 1);
	localparam logic [1:0] ANT_LAST = 2'(NUM_ANT - 1);

	// Bus side state
	logic aw_held_ff;
	logic w_held_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic wr_fire;
	logic [31:0] wmask;
	logic wr_hit;
	logic [31:0] rd_word;
	logic rd_hit;
	logic [7:0] rd_addr;

	// Software registers
	logic enable_ff;
	logic [NUM_EVENTS-1:0] int_stat_ff;
	logic [NUM_EVENTS-1:0] int_en_ff;
	logic [31:0] sat_ff [NUM_ANT];
	logic [31:0] flag_ff [NUM_ANT];
	logic measurement_query_command;

	// Framer state
	logic [TICK_W-1:0] tick_cnt_ff;
	logic [15:0] tag_ff;
	logic [15:0] tag_snap_ff;
	rmrf_state_e state_ff;
	logic [1:0] ant_ff;
	logic [4:0] idx_ff;
	logic [7:0] csum_ff;
	logic rec_valid_ff;
	logic [7:0] rec_data_ff;
	logic rec_first_ff;
	logic rec_last_ff;
	logic advance;
	logic load;
	logic [7:0] cur_byte;
	logic [NUM_EVENTS-1:0] events;

	// Conditioned fields per antenna
	logic [7:0] f_code [NUM_ANT];
	logic [6:0] f_elev [NUM_ANT];
	logic [8:0] f_az [NUM_ANT];
	logic [5:0] f_chan [NUM_ANT];
	logic [7:0] f_warn [NUM_ANT];

	// ----------------------------------------------------------------
	// AXI4-Lite write channels
	// ----------------------------------------------------------------
	// Address and data may arrive in either order; both are parked
	assign awready = !aw_held_ff && !bvalid_ff;
	assign wready = !w_held_ff && !bvalid_ff;
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
		{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
		end else if (awvalid && awready) begin
			aw_held_ff <= 1'b1;
			aw_addr_ff <= awaddr[ADDR_W-1:0];
		end else if (wr_fire) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff <= 1'b0;
			w_data_ff <= 32'h0;
			w_strb_ff <= 4'h0;
		end else if (wvalid && wready) begin
			w_held_ff <= 1'b1;
			w_data_ff <= wdata;
			w_strb_ff <= wstrb;
		end else if (wr_fire) begin
			w_held_ff <= 1'b0;
		end
	end

	// Write address decode; unmapped addresses answer SLVERR
	always_comb begin
		case (aw_addr_ff)
			REG_CTRL, REG_INT_CLR, REG_INT_EN: wr_hit = 1'b1;
			default: wr_hit = (aw_addr_ff[7:4] == SAT_PAGE) ||
				(aw_addr_ff[7:4] == FLAG_PAGE);
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	// Start bit is a write-one strobe and is never stored
	assign measurement_query_command = wr_fire && (aw_addr_ff == REG_CTRL) &&
		w_strb_ff[0] && w_data_ff[CTRL_START_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_ff <= CTRL_ENABLE_RST;
		end else if (wr_fire && (aw_addr_ff == REG_CTRL) && w_strb_ff[0]) begin
			enable_ff <= w_data_ff[CTRL_ENABLE_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_en_ff <= INT_EN_RST;
		end else if (wr_fire && (aw_addr_ff == REG_INT_EN) && w_strb_ff[0]) begin
			int_en_ff <= w_data_ff[NUM_EVENTS-1:0];
		end
	end

	// Satellite words; rewriting them mid-query changes later bytes only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int a = 0; a < NUM_ANT; a++) begin
				sat_ff[a] <= SAT_RST;
				flag_ff[a] <= FLAG_RST;
			end
		end else if (wr_fire && (aw_addr_ff[7:4] == SAT_PAGE)) begin
			sat_ff[aw_addr_ff[3:2]] <= (sat_ff[aw_addr_ff[3:2]] & ~wmask) |
				(w_data_ff & wmask);
		end else if (wr_fire && (aw_addr_ff[7:4] == FLAG_PAGE)) begin
			flag_ff[aw_addr_ff[3:2]] <= (flag_ff[aw_addr_ff[3:2]] & ~wmask) |
				(w_data_ff & wmask);
		end
	end

	// Sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_stat_ff <= '0;
		end else if (wr_fire && (aw_addr_ff == REG_INT_CLR) && w_strb_ff[0]) begin
			int_stat_ff <= (int_stat_ff & ~w_data_ff[NUM_EVENTS-1:0]) | events;
		end else begin
			int_stat_ff <= int_stat_ff | events;
		end
	end

	assign irq = |(int_stat_ff & int_en_ff);

	// ----------------------------------------------------------------
	// AXI4-Lite read channels
	// ----------------------------------------------------------------
	assign arready = !rvalid_ff;
	assign rd_addr = araddr[ADDR_W-1:0];

	// Read decode; the clear register reads as zero
	always_comb begin
		rd_word = 32'h0;
		rd_hit = 1'b1;
		case (rd_addr)
			REG_CTRL: rd_word = {31'h0, enable_ff};
			REG_STATUS: rd_word = {13'h0, ant_ff, (state_ff == ST_SEND), tag_ff};
			REG_INT_STAT: rd_word = {29'h0, int_stat_ff};
			REG_INT_CLR: rd_word = 32'h0;
			REG_INT_EN: rd_word = {29'h0, int_en_ff};
			default: begin
				if (rd_addr[7:4] == SAT_PAGE) begin
					rd_word = sat_ff[rd_addr[3:2]];
				end else if (rd_addr[7:4] == FLAG_PAGE) begin
					rd_word = flag_ff[rd_addr[3:2]];
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_word;
			rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;

	// ----------------------------------------------------------------
	// Sequence tag time base
	// ----------------------------------------------------------------
	// Free-running, so tags stay aligned to time even while idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_ff <= '0;
			tag_ff <= 16'h0;
		end else if (tick_cnt_ff == TICK_LAST) begin
			tick_cnt_ff <= '0;
			tag_ff <= (tag_ff == TAG_LAST) ? 16'h0 : tag_ff + 16'h1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Field conditioning per antenna
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NUM_ANT; g++) begin : g_ant
		rmrf_sat_field u_field (
			.sat_word(sat_ff[g]),
			.flag_word(flag_ff[g]),
			.code(f_code[g]),
			.elev(f_elev[g]),
			.az(f_az[g]),
			.chan(f_chan[g]),
			.warn(f_warn[g])
		);
	end

	// ----------------------------------------------------------------
	// Record byte selection
	// ----------------------------------------------------------------
	always_comb begin
		cur_byte = 8'h00;
		if (idx_ff < 5'(HDR_LEN)) begin
			cur_byte = HDR_BYTES[8*(HDR_LEN-1-int'(idx_ff)) +: 8];
		end else begin
			case (idx_ff)
				IDX_TAG_HI: cur_byte = tag_snap_ff[15:8];
				IDX_TAG_LO: cur_byte = tag_snap_ff[7:0];
				IDX_REMAIN: cur_byte = {6'h0, ANT_LAST - ant_ff};
				IDX_CODE: cur_byte = f_code[ant_ff];
				IDX_ELEV: cur_byte = {1'b0, f_elev[ant_ff]};
				IDX_AZ_HI: cur_byte = {7'h0, f_az[ant_ff][8]};
				IDX_AZ_LO: cur_byte = f_az[ant_ff][7:0];
				IDX_CHAN: cur_byte = {2'h0, f_chan[ant_ff]};
				IDX_WARN: cur_byte = f_warn[ant_ff];
				IDX_CSUM: cur_byte = csum_ff;
				default: cur_byte = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Framing sequencer
	// ----------------------------------------------------------------
	// During a query the output register refills whenever it is empty or being taken
	assign advance = !rec_valid_ff || rec_ready;
	assign load = advance && (state_ff == ST_SEND);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ST_IDLE;
			ant_ff <= 2'h0;
			idx_ff <= 5'h0;
			tag_snap_ff <= 16'h0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (measurement_query_command && enable_ff) begin
						state_ff <= ST_SEND;
						ant_ff <= 2'h0;
						idx_ff <= 5'h0;
						tag_snap_ff <= tag_ff;
					end
				end
				ST_SEND: begin
					if (load && idx_ff == REC_LAST_IDX) begin
						idx_ff <= 5'h0;
						if (ant_ff == ANT_LAST) begin
							state_ff <= ST_IDLE;
						end else begin
							ant_ff <= ant_ff + 2'h1;
						end
					end else if (load) begin
						idx_ff <= idx_ff + 5'h1;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Running XOR over tag through warning bytes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			csum_ff <= 8'h00;
		end else if (load && idx_ff < IDX_TAG_HI) begin
			csum_ff <= 8'h00;
		end else if (load && idx_ff < IDX_CSUM) begin
			csum_ff <= csum_ff ^ cur_byte;
		end
	end

	// Registered stream output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rec_valid_ff <= 1'b0;
			rec_data_ff <= 8'h00;
			rec_first_ff <= 1'b0;
			rec_last_ff <= 1'b0;
		end else if (load) begin
			rec_valid_ff <= 1'b1;
			rec_data_ff <= cur_byte;
			rec_first_ff <= (idx_ff == 5'h0);
			rec_last_ff <= (idx_ff == REC_LAST_IDX);
		end else if (advance) begin
			rec_valid_ff <= 1'b0;
			rec_first_ff <= 1'b0;
			rec_last_ff <= 1'b0;
		end
	end

	assign rec_valid = rec_valid_ff;
	assign rec_data = rec_data_ff;
	assign rec_first = rec_first_ff;
	assign rec_last = rec_last_ff;

	// ----------------------------------------------------------------
	// Interrupt events
	// ----------------------------------------------------------------
	// A query while busy or disabled is dropped, not queued
	always_comb begin
		events = '0;
		events[EV_RECORD_DONE] = load && (idx_ff == REC_LAST_IDX);
		events[EV_QUERY_DONE] = load && (idx_ff == REC_LAST_IDX) &&
			(ant_ff == ANT_LAST);
		events[EV_QUERY_REFUSED] = measurement_query_command &&
			((state_ff != ST_IDLE) || !enable_ff);
	end

endmodule

// >>> dv/rmrf_framer_checker.sv
// Assertion checker for the record byte stream of the framer
`timescale 1ns/1ps
module rmrf_framer_checker
	import rmrf_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Record stream
	input wire logic rec_valid,
	input wire logic rec_ready,
	input wire logic [7:0] rec_data,
	input wire logic rec_first,
	input wire logic rec_last
);
	// --------------------
	// Position tracking
	// --------------------
	logic hs;
	logic [4:0] bi_ff;
	logic [1:0] rc_ff;
	logic [7:0] acc_ff;
	logic [7:0] th_ff;
	logic [7:0] tl_ff;
	logic azh_ff;

	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Byte taken by the host
	assign hs = rec_valid && rec_ready;

	// Byte and record index, so each byte is judged by its place
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bi_ff <= 5'h0;
			rc_ff <= 2'h0;
		end else if (hs) begin
			bi_ff <= rec_last ? 5'h0 : bi_ff + 5'h1;
			rc_ff <= rc_ff + {1'b0, rec_last};
		end
	end

	// Running XOR, first record's tag, azimuth top bit
	always_ff @(posedge aclk) begin
		if (hs) begin
			acc_ff <= (bi_ff > 5'd10 && bi_ff < 5'd20) ? acc_ff ^ rec_data : 8'h0;
			if (rc_ff == 2'd0 && bi_ff == 5'd11) th_ff <= rec_data;
			if (rc_ff == 2'd0 && bi_ff == 5'd12) tl_ff <= rec_data;
			if (bi_ff == 5'd16) azh_ff <= rec_data[0];
		end
	end

	// --------------------
	// Stream assertions
	// --------------------
	hold_byte_a: assert property (rec_valid && !rec_ready |=>
		rec_valid && $stable({rec_data, rec_first, rec_last}))
		else $error("record byte changed before it was taken");
	no_bubble_a: assert property (hs && !(rec_last && rc_ff == 2'd3) |=>
		rec_valid)
		else $error("gap inside a query");
	frame_marks_a: assert property (rec_valid |->
		rec_first == (bi_ff == 5'd0) && rec_last == (bi_ff == 5'd20))
		else $error("first or last mark misplaced");
	header_bytes_a: assert property (rec_valid && bi_ff < 5'd11 |->
		rec_data == HDR_BYTES[87 - 8*bi_ff -: 8])
		else $error("header byte wrong");
	same_tag_a: assert property (rec_valid && rc_ff != 2'd0 &&
		(bi_ff == 5'd11 || bi_ff == 5'd12) |->
		rec_data == (bi_ff == 5'd11 ? th_ff : tl_ff))
		else $error("tag differs within a query");
	remain_count_a: assert property (rec_valid && bi_ff == 5'd13 |->
		rec_data == 8'd3 - 8'(rc_ff))
		else $error("remaining count wrong");
	elev_range_a: assert property (rec_valid && bi_ff == 5'd15 |->
		rec_data <= 8'd90)
		else $error("elevation above limit");
	az_high_a: assert property (rec_valid && bi_ff == 5'd16 |->
		rec_data[7:1] == 7'h0)
		else $error("azimuth high byte too wide");
	az_range_a: assert property (rec_valid && bi_ff == 5'd17 |->
		{azh_ff, rec_data} <= 9'd360)
		else $error("azimuth above limit");
	chan_range_a: assert property (rec_valid && bi_ff == 5'd18 |->
		rec_data >= 8'd1 && rec_data <= 8'd32)
		else $error("channel out of range");
	warn_bits_a: assert property (rec_valid && bi_ff == 5'd19 |->
		rec_data[6:3] == 4'h0)
		else $error("unused warning weight set");
	record_csum_a: assert property (rec_valid && rec_last |->
		rec_data == acc_ff)
		else $error("checksum wrong");
endmodule

bind rmrf_framer rmrf_framer_checker chk_i (.aclk, .aresetn, .rec_valid,
	.rec_ready, .rec_data, .rec_first, .rec_last);

// >>> dv/rmrf_host_sink.sv
// Host-side sink model for the record byte stream
`timescale 1ns/1ps
module rmrf_host_sink
	import rmrf_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Record stream
	input wire logic rec_valid,
	output logic rec_ready = 1'b0,
	input wire logic [7:0] rec_data,
	input wire logic rec_first,
	input wire logic rec_last,
	// Bench control
	input wire logic stall
);
	logic [7:0] got[$];
	logic [1:0] marks[$];
	logic [7:0] sum = 8'h0;
	int pos = 0;
	int bad = 0;

	// Slow host takes a byte only every other cycle
	always @(posedge aclk) begin
		if (!aresetn) rec_ready <= 1'b0;
		else rec_ready <= stall ? !rec_ready : 1'b1;
	end

	// Realigns on each record start and checks its XOR
	always @(posedge aclk) begin
		if (aresetn && rec_valid && rec_ready) begin
			got.push_back(rec_data);
			marks.push_back({rec_first, rec_last});
			if (rec_first) pos = 0;
			if (pos == 11) sum = rec_data;
			else if (pos > 11 && pos < 20) sum = sum ^ rec_data;
			if (pos == 20 && rec_data !== sum) bad++;
			pos++;
		end
	end
endmodule

// >>> dv/rmrf_framer_tb.sv
// Self-checking bench for the measurement record framer
`timescale 1ns/1ps
module rmrf_framer_tb;
	import rmrf_pkg::*;
	// --------------------
	// Stimulus and expectations
	// --------------------
	localparam logic [31:0] SAT[4] = '{32'h00c82d05, 32'h51ff7f1f,
		32'h41685a20, 32'h020000ff};
	localparam logic [31:0] FLG[4] = '{32'h17, 32'h3c, 32'h13, 32'h54};
	// Bytes 13..19 expected per antenna: clamped, in antenna order
	localparam logic [55:0] EXP[4] = '{56'h03052d00c80103,
		56'h021f5a01682080, 56'h01205a01682007, 56'h00ff0000000100};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic stall = 1'b0;
	logic [31:0] awaddr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] araddr = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic rec_valid, rec_ready, rec_first, rec_last;
	logic [7:0] rec_data;
	int n_mismatch = 0;
	int checked = 0;

	// Two-cycle tag tick, so the tag wrap is reachable in the run
	localparam int TICK = 2;
	rmrf_framer #(.TICK_CYCLES(TICK)) uut (.aclk, .aresetn, .awvalid,
		.awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
		.wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
		.rec_valid, .rec_ready, .rec_data, .rec_first, .rec_last, .irq);
	rmrf_host_sink sink (.aclk, .aresetn, .rec_valid, .rec_ready,
		.rec_data, .rec_first, .rec_last, .stall);

	always #5 aclk = ~aclk;

	// --------------------
	// Shared tasks
	// --------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		chk(32'(rresp), 32'(er));
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// --------------------
	// Scenarios
	// --------------------
	task automatic t_regs();
		logic [31:0] d;
		rd(REG_CTRL, d, RESP_OKAY);
		chk(d, 32'h1);
		rd(REG_INT_EN, d, RESP_OKAY);
		chk(d, 32'h0);
		rd(REG_INT_CLR, d, RESP_OKAY);
		chk(d, 32'h0);
		rd(8'h44, d, RESP_SLVERR);
		chk(d, 32'h0);
		wr(8'h44, 32'h5, RESP_SLVERR);
		$display("t_regs done");
	endtask

	// Reads exactly 104 cycles apart, a whole number of ticks
	task automatic t_tag();
		logic [31:0] d1, d2;
		logic [15:0] df;
		rd(REG_STATUS, d1, RESP_OKAY);
		repeat (101) @(posedge aclk);
		rd(REG_STATUS, d2, RESP_OKAY);
		df = d2[15:0] - d1[15:0];
		chk(32'(df), 32'(104 / TICK));
		$display("t_tag done");
	endtask

	// Waits past the last tag value; a plain 16-bit count would miss 3
	task automatic t_wrap();
		logic [31:0] d1, d2;
		int w;
		rd(REG_STATUS, d1, RESP_OKAY);
		w = TICK * (int'(TAG_LAST) + 4 - int'(d1[15:0])) - 3;
		repeat (w) @(posedge aclk);
		rd(REG_STATUS, d2, RESP_OKAY);
		chk(32'(d2[15:0]), 32'd3);
		$display("t_wrap done");
	endtask

	// Four records under a stalling host, second start while busy
	task automatic t_query();
		logic [31:0] d, b, fx, cs;
		logic [15:0] t0, tg;
		int a, i, k;
		wr(REG_INT_EN, 32'h7, RESP_OKAY);
		for (a = 0; a < 4; a++) begin
			wr(8'h20 + 8'(4*a), SAT[a], RESP_OKAY);
			wr(8'h30 + 8'(4*a), FLG[a], RESP_OKAY);
		end
		rd(REG_STATUS, d, RESP_OKAY);
		t0 = d[15:0];
		stall <= 1'b1;
		wr(REG_CTRL, 32'h3, RESP_OKAY);
		wr(REG_CTRL, 32'h3, RESP_OKAY);
		for (k = 0; k < 3000 && sink.got.size() < 84; k++) @(posedge aclk);
		stall <= 1'b0;
		chk(32'(sink.got.size()), 32'd84);
		tg = {sink.got[11], sink.got[12]};
		chk(32'(tg - t0), 32'(4 / TICK));
		cs = 32'h0;
		for (k = 0; k < 84 && k < sink.got.size(); k++) begin
			a = k / 21;
			i = k % 21;
			b = 32'(sink.got[k]);
			fx = (i > 12 && i < 20) ? 32'(EXP[a][159-8*i -: 8]) : 32'h0;
			if (i == 0) cs = 32'h0;
			if (i > 10 && i < 20) cs = cs ^ b;
			chk(32'(sink.marks[k]), 32'({i == 0, i == 20}));
			if (i < 11) chk(b, 32'(HDR_BYTES[87-8*i -: 8]));
			else if (i < 13) chk(b, 32'(tg[103-8*i -: 8]));
			else if (i == 13) chk(b, fx);
			else if (i == 14) chk(b, fx);
			else if (i < 19) chk(b, fx);
			else if (i == 19) chk(b, fx);
			else chk(b, cs);
		end
		chk(32'(sink.got[61]), 32'h7);
		chk(32'(sink.got[82]), 32'h0);
		chk(32'(sink.bad), 32'h0);
		$display("t_query done");
	endtask

	// Events raised by the query, then masked and cleared
	task automatic t_irq();
		logic [31:0] d;
		chk(32'(irq), 32'h1);
		rd(REG_INT_STAT, d, RESP_OKAY);
		chk(d, 32'h7);
		wr(REG_INT_EN, 32'h0, RESP_OKAY);
		chk(32'(irq), 32'h0);
		wr(REG_INT_CLR, 32'h7, RESP_OKAY);
		rd(REG_INT_STAT, d, RESP_OKAY);
		chk(d, 32'h0);
		$display("t_irq done");
	endtask

	// --------------------
	// Main sequence and watchdog
	// --------------------
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_tag();
		t_query();
		t_irq();
		t_wrap();
		tally_and_finish();
	end

	// Whole run needs about 72,000 cycles, mostly the tag wrap
	initial begin
		repeat (90000) @(posedge aclk);
		n_mismatch++;
		$display("ERROR %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule
